// *** sep_port_ddr_sram_access_bench.sv ***
// Self-checking bench for the double-rate burst SRAM block
`timescale 1ns/100ps
`default_nettype none
`include "spd_consts.svh"
module sep_port_ddr_sram_access_bench;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic pll_off_n = 1'b1;
   logic k_pin, k_n_pin, rps_n, wps_n, q_oe_n;
   logic [1:0] lws_n;
   logic [`SPD_AW-1:0] addr;
   logic [`SPD_ORG-1:0] d, q;
   logic [`SPD_ORG-1:0] mem [64];
   logic [`SPD_ORG-1:0] eq[$];
   int ek[$];
   int errors = 0;
   int checks = 0;
   int lat = 2;
   spd_sram i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .k_pin(k_pin), .k_n_pin(k_n_pin),
      .read_port_select_n(rps_n), .write_port_select_n(wps_n), .lane_write_select_n(lws_n),
      .addr_pin(addr), .d_pin(d), .pll_off_n(pll_off_n), .q_data(q), .q_oe_n(q_oe_n));
   spd_host_model i_host (.sys_clk(sys_clk), .k_pin(k_pin), .k_n_pin(k_n_pin),
      .read_port_select_n(rps_n), .write_port_select_n(wps_n), .lane_write_select_n(lws_n),
      .addr_pin(addr), .d_pin(d), .q_data(q), .q_oe_n(q_oe_n));
   // --------
   // Checking
   // --------
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic cmp_word(input string n, input logic [17:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_word
   task automatic cmp_num(input string n, input int e, g);
      checks++;
      if (g != e) begin
         errors++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      end
   endtask : cmp_num
   task automatic conclude;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] m);
      merge = o;
      if (!m[0]) merge[8:0] = n[8:0];
      if (!m[1]) merge[17:9] = n[17:9];
   endfunction : merge
   // One K cycle of traffic; the reference memory follows each word's mask
   task automatic acc(input logic rd, wr, input logic [5:0] ra, wa,
         input logic [17:0] w0, w1, input logic [1:0] m0, m1);
      int t;
      i_host.op(rd, wr, ra, wa, w0, w1, m0, m1, t);
      if (wr) begin
         mem[wa] = merge(mem[wa], w0, m0);
         mem[6'(wa + 1)] = merge(mem[6'(wa + 1)], w1, m1);
      end
      if (rd) begin
         eq.push_back(mem[ra]);
         eq.push_back(mem[6'(ra + 1)]);
         ek.push_back(t + lat);
         ek.push_back(t + lat);
      end
   endtask : acc
   // Let bursts finish, then match each captured word and its K cycle
   task automatic drain;
      repeat (36) @(posedge sys_clk);
      cmp_num("word count", eq.size(), i_host.rq.size());
      foreach (eq[i]) begin
         if (i < i_host.rq.size()) begin
            cmp_word("read word", eq[i], i_host.rq[i]);
            cmp_num("read K cycle", ek[i], i_host.rk[i]);
         end
      end
      cmp_word("output enable", 18'h00001, {17'h00000, q_oe_n});
      eq.delete();
      ek.delete();
      i_host.rq.delete();
      i_host.rk.delete();
   endtask : drain
   task automatic s_idle;
      repeat (4) begin
         repeat (12) @(posedge sys_clk);
         cmp_word("idle enable", 18'h00001, {17'h00000, q_oe_n});
      end
   endtask : s_idle
   // Full words, including a burst that wraps past the top address
   task automatic s_full;
      acc(1'b0, 1'b1, 6'h00, 6'h05, 18'h12345, 18'h2BCDE, 2'h0, 2'h0);
      acc(1'b0, 1'b1, 6'h00, 6'h3F, 18'h0F0F0, 18'h3C3C3, 2'h0, 2'h0);
      acc(1'b1, 1'b0, 6'h05, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      acc(1'b1, 1'b0, 6'h3F, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      drain();
   endtask : s_full
   // Every mask code on word 0, its inverse on word 1
   task automatic s_masks;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 1'b1, 6'h00, 6'(8 + 2 * i), 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
         acc(1'b0, 1'b1, 6'h00, 6'(8 + 2 * i), 18'h12345, 18'h0ABCD, 2'(i), 2'(~i));
         acc(1'b1, 1'b0, 6'(8 + 2 * i), 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      end
      drain();
   endtask : s_masks
   // Read right after a write, read and write together, back-to-back reads
   task automatic s_fwd;
      acc(1'b0, 1'b1, 6'h00, 6'h14, 18'h2468A, 18'h13579, 2'h0, 2'h0);
      acc(1'b1, 1'b0, 6'h14, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      acc(1'b1, 1'b1, 6'h1E, 6'h1E, 18'h3A5A5, 18'h05A5A, 2'h0, 2'h0);
      acc(1'b1, 1'b0, 6'h08, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      drain();
   endtask : s_fwd
   // Clocks stopped while the second word is out: outputs must hold it
   task automatic s_stop;
      acc(1'b1, 1'b0, 6'h14, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      i_host.freeze(i_host.kcnt + lat);
      repeat (48) @(posedge sys_clk);
      cmp_word("stopped data", mem[6'h15], q);
      cmp_word("stopped enable", 18'h00000, {17'h00000, q_oe_n});
      i_host.thaw();
      drain();
   endtask : s_stop
   task automatic s_lat1;
      @(posedge sys_clk);
      pll_off_n <= 1'b0;
      repeat (24) @(posedge sys_clk);
      lat = 1;
      acc(1'b1, 1'b0, 6'h05, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      acc(1'b1, 1'b0, 6'h14, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      drain();
   endtask : s_lat1
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      s_idle();
      s_full();
      s_masks();
      s_fwd();
      s_stop();
      s_lat1();
      conclude();
   end
   // Whole run is under 100 K cycles, 1,200 sys_clk; far beyond that means a hang
   initial begin
      repeat (6000) @(posedge sys_clk);
      errors++;
      conclude();
   end
endmodule : sep_port_ddr_sram_access_bench
`default_nettype wire

// *** spd_consts.svh ***
// Constants for the separate-port double-rate SRAM access block
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH
// Organisation: 8, 9 or 18 bits per data word
`define SPD_ORG 18
// Address bits of the flop-based array
`define SPD_AW 6
// Reset values
`define SPD_OE_N_RST 1'h1
`define SPD_DATA_RST 18'h00000
// Pin synchroniser depth
`define SPD_SYNC_STAGES 2
`endif

// *** spd_host_model.sv ***
// Host controller model driving the SRAM pins and capturing read words
`timescale 1ns/100ps
`default_nettype none
`include "spd_consts.svh"
module spd_host_model (
   input wire logic sys_clk, // System clock
   output logic k_pin, // Positive input clock
   output logic k_n_pin, // Negative input clock
   output logic read_port_select_n, // Read select
   output logic write_port_select_n, // Write select
   output logic [1:0] lane_write_select_n, // Lane selects
   output logic [`SPD_AW-1:0] addr_pin, // Address
   output logic [`SPD_ORG-1:0] d_pin, // Write data
   input wire logic [`SPD_ORG-1:0] q_data, // Read data
   input wire logic q_oe_n // Low while read data driven
);
   int phase = 0;
   int kcnt = 0;
   logic hold_clk = 1'b0;
   logic [`SPD_ORG-1:0] rq[$];
   int rk[$];
   // ------
   // Clocks
   // ------
   // Twelve sys_clk per K cycle keeps each half well past the pin delay
   // Both clocks stop at their present levels while hold_clk is set
   always @(posedge sys_clk) begin
      if (!hold_clk) begin
         phase <= (phase == 11) ? 0 : phase + 1;
         kcnt <= (phase == 11) ? kcnt + 1 : kcnt;
      end
   end
   assign k_pin = (phase < 6);
   assign k_n_pin = (phase >= 6);
   initial begin
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      lane_write_select_n = 2'h3;
      addr_pin = '0;
      d_pin = '0;
   end
   // Sample late in each half, once the registered word has settled
   always @(posedge sys_clk) begin
      if ((phase == 5 || phase == 11) && q_oe_n === 1'b0) begin
         rq.push_back(q_data);
         rk.push_back(kcnt);
      end
   end
   // Selects and word 0 three sys_clk before K, address and word 1 before K#
   task automatic op(input logic rd, wr, input logic [`SPD_AW-1:0] ra, wa,
         input logic [`SPD_ORG-1:0] w0, w1, input logic [1:0] m0, m1, output int t);
      do @(posedge sys_clk); while (phase != 8);
      read_port_select_n <= ~rd;
      write_port_select_n <= ~wr;
      addr_pin <= ra;
      d_pin <= wr ? w0 : ~d_pin;
      lane_write_select_n <= m0;
      t = kcnt + 1;
      do @(posedge sys_clk); while (phase != 2);
      read_port_select_n <= 1'b1;
      write_port_select_n <= 1'b1;
      addr_pin <= wa;
      d_pin <= wr ? w1 : ~d_pin;
      lane_write_select_n <= m1;
      do @(posedge sys_clk); while (phase != 7);
      // Hold is over; released lines flip so no stale word survives
      addr_pin <= ~addr_pin;
      d_pin <= ~d_pin;
   endtask : op
   // Stop the clocks in K cycle k just after its K# rise, K# left high;
   // parking K high too would itself make a K rise, so it is left low
   task automatic freeze(input int k);
      do @(posedge sys_clk); while (phase != 9 || kcnt != k);
      hold_clk <= 1'b1;
   endtask : freeze
   // Restart the clocks where they stopped
   task automatic thaw;
      @(posedge sys_clk);
      hold_clk <= 1'b0;
   endtask : thaw
endmodule : spd_host_model
`default_nettype wire

// *** spd_pkg.sv ***
// Types for the separate-port double-rate SRAM access block
`default_nettype none
package spd_pkg;
   // Read output sequencer states
   typedef enum logic [1:0] {
      SPD_RD_IDLE = 2'b00,
      SPD_RD_FIRST = 2'b01,
      SPD_RD_SECOND = 2'b10
   } spd_rd_state_t;
endpackage : spd_pkg
`default_nettype wire

// *** spd_sram.sv ***
// Separate read/write port double-rate burst SRAM, device side
`timescale 1ns/100ps
`default_nettype none
`include "spd_consts.svh"

// Function
// [RQ1] Write select low at K rise starts a write; word1 and address come on K#.
// [RQ2] Read select low at K edge t latches address; words driven at K t+2, K#.
// [RQ3] A burst moves word A, then word A plus one.
// [RQ4] Write data registered and read data launched on both K and K# rises.
// [RQ5] After power-up the device is deselected with read outputs tri-stated.
// [RQ6] Host may park clocks high when stopped; outputs keep previous state. Code: raising a low clock to park it is taken as one more rise.
// [RQ7] Write selects sampled separately per data word; each word uses its own mask.
// [RQ8] Both selects low: whole word written.
// [RQ9] Select 0 low, select 1 high: only low lane written.
// [RQ10] Select 0 high, select 1 low: only upper lane written.
// [RQ11] Both selects high: that half of the burst leaves memory unchanged.
// [RQ12] Nine-bit organisation: one select writes all nine bits or nothing.
// [RQ13] PLL-off input low gives a read latency of one cycle.
// [RQ14] Read deselect finishes pending bursts, then tri-states after next K rise.
// [RQ15] Reads return newest data, forwarded from a concurrent or recent write.
// [RQ16] Port selects sampled only on K rises; ports do not disturb each other.
// [RQ17] Both selects high: no new access, inputs ignored, idle outputs tri-stated.
module spd_sram
   import spd_pkg::*;
(
   input wire logic sys_clk, // System clock, 200 MHz
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic k_pin, // Positive input clock, sampled
   input wire logic k_n_pin, // Negative input clock, sampled
   input wire logic read_port_select_n, // Read port select, active low
   input wire logic write_port_select_n, // Write port select, active low
   input wire logic [1:0] lane_write_select_n, // Lane/half-byte write selects
   input wire logic [`SPD_AW-1:0] addr_pin, // Shared address bus
   input wire logic [`SPD_ORG-1:0] d_pin, // Write data inputs
   input wire logic pll_off_n, // Low selects one-cycle latency
   output logic [`SPD_ORG-1:0] q_data, // Read data, registered
   output logic q_oe_n // Read output enable, low while driving
);
   localparam int DW = `SPD_ORG;
   localparam int AW = `SPD_AW;
   localparam int DEPTH = 1 << AW;
   localparam int LOW_W = DW / 2;
   localparam bit SINGLE = (DW == 9);
   localparam int SW = 7 + DW + AW;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [SW-1:0] pin_s1_reg;
   logic [SW-1:0] pin_s2_reg;
   logic k_prev_reg;
   logic kn_prev_reg;

   // Every pin takes the same two stages so data stays aligned to its clocks
   always_ff @(posedge sys_clk) begin
      pin_s1_reg <= {k_pin, k_n_pin, read_port_select_n, write_port_select_n,
                     lane_write_select_n, addr_pin, d_pin, pll_off_n};
      pin_s2_reg <= pin_s1_reg;
   end

   logic k_s, kn_s, rps_n_s, wps_n_s, pll_off_n_s;
   logic [1:0] ws_n_s;
   logic [AW-1:0] addr_s;
   logic [DW-1:0] d_s;
   assign {k_s, kn_s, rps_n_s, wps_n_s, ws_n_s, addr_s, d_s, pll_off_n_s} = pin_s2_reg;

   // Edge detect on synced clocks; a stopped clock simply gives no edges
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         k_prev_reg <= 1'h1;
         kn_prev_reg <= 1'h1;
      end else begin
         k_prev_reg <= k_s;
         kn_prev_reg <= kn_s;
      end
   end

   logic k_rise, kn_rise, lat1_mode;
   assign k_rise = k_s & ~k_prev_reg;
   assign kn_rise = kn_s & ~kn_prev_reg;
   assign lat1_mode = ~pll_off_n_s; // see [RQ13]

   // -----------------------------------------------------------------
   // Write port
   // -----------------------------------------------------------------
   logic wr_pend_reg;
   logic [DW-1:0] wr_d0_reg;
   logic [1:0] wr_ws0_reg;
   logic wr_commit;
   logic [AW-1:0] wa0, wa1;
   logic [DW-1:0] mem_reg [DEPTH];
   logic [DW-1:0] wr_word0_next, wr_word1_next;

   // Merge new data into the stored word under a two-bit active-low mask
   function automatic logic [DW-1:0] spd_merge(input logic [DW-1:0] old_w,
                                                input logic [DW-1:0] new_w,
                                                input logic [1:0] ws_n);
      logic [DW-1:0] res;
      res = old_w;
      if (SINGLE) begin
         if (!ws_n[0]) res = new_w; // see [RQ12]
      end else begin
         if (!ws_n[0]) res[LOW_W-1:0] = new_w[LOW_W-1:0]; // see [RQ8] [RQ9]
         if (!ws_n[1]) res[DW-1:LOW_W] = new_w[DW-1:LOW_W]; // see [RQ8] [RQ10]
      end
      return res; // Both high leaves old_w, see [RQ11]
   endfunction : spd_merge

   // Word0 and its mask taken on K; a deselected port ignores the pins
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'h0;
         wr_d0_reg <= '0;
         wr_ws0_reg <= 2'h3;
      end else if (k_rise && !wps_n_s) begin
         wr_pend_reg <= 1'h1; // see [RQ1] [RQ16]
         wr_d0_reg <= d_s; // see [RQ4]
         wr_ws0_reg <= ws_n_s; // see [RQ7]
      end else if (wr_commit) begin
         wr_pend_reg <= 1'h0;
      end
   end

   // Address and word1 come on K#; both words commit together then
   assign wr_commit = kn_rise & wr_pend_reg; // see [RQ1]
   assign wa0 = addr_s;
   assign wa1 = AW'(addr_s + 1'b1); // see [RQ3]
   assign wr_word0_next = spd_merge(mem_reg[wa0], wr_d0_reg, wr_ws0_reg);
   assign wr_word1_next = spd_merge(mem_reg[wa1], d_s, ws_n_s); // see [RQ7]

   // Array entries, one flop word each
   for (genvar gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_ff @(posedge sys_clk) begin
         if (wr_commit && wa1 == AW'(gi)) begin
            mem_reg[gi] <= wr_word1_next;
         end else if (wr_commit && wa0 == AW'(gi)) begin
            mem_reg[gi] <= wr_word0_next;
         end
      end
   end

   // Newest value of a word, including a write committing this cycle
   function automatic logic [DW-1:0] spd_fresh(input logic [AW-1:0] a);
      logic [DW-1:0] res;
      res = mem_reg[a];
      if (wr_commit && a == wa0) res = wr_word0_next; // see [RQ15]
      if (wr_commit && a == wa1) res = wr_word1_next; // see [RQ15]
      return res;
   endfunction : spd_fresh

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   logic rd_p1_v_reg, rd_p2_v_reg;
   logic [AW-1:0] rd_p1_addr_reg, rd_p2_addr_reg, rd_addr_reg;
   logic rd_launch;
   logic [AW-1:0] rd_sel_addr;
   spd_rd_state_t rd_state_reg;

   // Request pipeline advances on K only; selects are never looked at on K#
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rd_p1_v_reg <= 1'h0;
         rd_p2_v_reg <= 1'h0;
         rd_p1_addr_reg <= '0;
         rd_p2_addr_reg <= '0;
      end else if (k_rise) begin
         rd_p1_v_reg <= ~rps_n_s; // see [RQ2] [RQ16] [RQ17]
         rd_p1_addr_reg <= addr_s;
         rd_p2_v_reg <= rd_p1_v_reg;
         rd_p2_addr_reg <= rd_p1_addr_reg;
      end
   end

   // One stage less in legacy mode
   assign rd_launch = k_rise & (lat1_mode ? rd_p1_v_reg : rd_p2_v_reg); // see [RQ13] [RQ2]
   assign rd_sel_addr = lat1_mode ? rd_p1_addr_reg : rd_p2_addr_reg;

   // Output sequencer: word A on K, word A+1 on K#, release on an idle K
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rd_state_reg <= SPD_RD_IDLE;
         rd_addr_reg <= '0;
         q_data <= `SPD_DATA_RST;
         q_oe_n <= `SPD_OE_N_RST; // see [RQ5]
      end else begin
         case (rd_state_reg)
            SPD_RD_IDLE, SPD_RD_SECOND: begin
               if (rd_launch) begin
                  rd_state_reg <= SPD_RD_FIRST;
                  rd_addr_reg <= rd_sel_addr;
                  q_data <= spd_fresh(rd_sel_addr); // see [RQ2] [RQ4]
                  q_oe_n <= 1'h0;
               end else if (k_rise) begin
                  rd_state_reg <= SPD_RD_IDLE;
                  q_oe_n <= 1'h1; // see [RQ14] [RQ17]
               end
            end
            SPD_RD_FIRST: begin
               // Pending second word is always finished, even if deselected
               if (kn_rise) begin
                  rd_state_reg <= SPD_RD_SECOND;
                  q_data <= spd_fresh(AW'(rd_addr_reg + 1'b1)); // see [RQ3] [RQ4]
               end
            end
            default: begin
               rd_state_reg <= SPD_RD_IDLE;
               q_oe_n <= 1'h1;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_commit_on_kn: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ1]
      wr_commit |-> kn_rise && $past(wr_pend_reg) == 1'b1)
      else $error("write committed outside a negative clock edge");

   a_full_word: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ8]
      (wr_commit && wr_ws0_reg == 2'b00 && wa0 != wa1) |=> mem_reg[$past(wa0)] == $past(wr_d0_reg))
      else $error("full word write lost data");

   a_low_lane: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ9]
      (wr_commit && ws_n_s == 2'b10 && !SINGLE) |=>
      mem_reg[$past(wa1)][DW-1:LOW_W] == $past(mem_reg[wa1][DW-1:LOW_W]) &&
      mem_reg[$past(wa1)][LOW_W-1:0] == $past(d_s[LOW_W-1:0]))
      else $error("low lane write wrong");

   a_upper_lane: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ10]
      (wr_commit && ws_n_s == 2'b01 && !SINGLE) |=>
      mem_reg[$past(wa1)][LOW_W-1:0] == $past(mem_reg[wa1][LOW_W-1:0]))
      else $error("upper lane write disturbed low lane");

   a_no_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ11] [RQ7]
      (wr_commit && ws_n_s == 2'b11 && wa0 != wa1) |=> mem_reg[$past(wa1)] == $past(mem_reg[wa1]))
      else $error("masked half of burst changed memory");

   a_second_fresh: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ3] [RQ15]
      (rd_state_reg == SPD_RD_FIRST && kn_rise) |=>
      q_data == mem_reg[AW'(rd_addr_reg + 1'b1)] && !q_oe_n)
      else $error("second read word not newest A plus one");

   a_idle_release: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ14] [RQ17]
      (k_rise && !rd_launch && rd_state_reg != SPD_RD_FIRST) |=> q_oe_n)
      else $error("outputs not released on idle positive edge");

   a_launch_drive: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ2] [RQ13]
      rd_launch |=> !q_oe_n && rd_state_reg == SPD_RD_FIRST &&
      q_data == mem_reg[rd_addr_reg])
      else $error("read launch did not drive first word");

   a_data_on_edge: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ4]
      $changed(q_data) |-> $past(k_rise) || $past(kn_rise))
      else $error("read data moved without an input clock edge");

   a_select_on_k: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ16]
      $changed(rd_p1_v_reg) |-> $past(k_rise))
      else $error("read select sampled off the positive edge");

endmodule : spd_sram
`default_nettype wire
